/* File: rtl/tfc_timer.sv */
`timescale 1ns/1ps
// How it works
// - code 0 normal, 1-3/5-7 8-10 bit PWM
// - codes 8,9 phase-frequency correct PWM
// - 10,11 phase correct; 14,15 fast PWM
// - clock select 0 stops, 1-5 prescaler taps
// - code 6 falling, code 7 rising pin edges
// - pin counts even when used as output
// - force bits only act in non-PWM modes
// - force applies match using current output mode
// - force raises no interrupt, never clears counter
// - force bits are strobes, read zero
// - force register bits 4:0 reserved, zero
// - counter readable/writable as two bytes
// - shared temporary high byte makes access atomic
// - counter write blocks next timer-clock match
// - output mode off, toggle, clear, set
// - control B bits 4:3 wave, 2:0 clock
module tfc_timer (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count pin and capture value
    input wire logic ext_count_pin,
    input wire logic [15:0] capture_value,
    // Waveform outputs
    output logic [2:0] wave_out,
    output logic [2:0] wave_out_en
);

    // TOP of the fixed-width PWM modes from the two low code bits
    function automatic logic [15:0] pwm_top(input logic [1:0] bits_code);
        case (bits_code)
            2'h2: pwm_top = 16'h01FF;
            2'h3: pwm_top = 16'h03FF;
            default: pwm_top = 16'h00FF;
        endcase
    endfunction : pwm_top

    // Waveform decode of the four-bit mode field
    function automatic tfc_pkg::tfc_wave_type decode_wave(input logic [3:0] m);
        tfc_pkg::tfc_wave_type w;
        // Default: plain up count to full scale
        w = '{tfc_pkg::tfc_up_wrap, 1'b0, 1'b0, 1'b0, 16'hFFFF};
        case (m)
            tfc_pkg::wave_normal: w.fixed_top = 16'hFFFF;
            4'h1, 4'h2, 4'h3: begin
                w.style = tfc_pkg::tfc_up_down;
                w.pwm = 1'b1;
                w.fixed_top = pwm_top(m[1:0]);
            end
            4'h5, 4'h6, 4'h7: begin
                w.style = tfc_pkg::tfc_up_fast;
                w.pwm = 1'b1;
                w.fixed_top = pwm_top(m[1:0]);
            end
            tfc_pkg::wave_ctc_a, tfc_pkg::wave_ctc_a2: w.top_from_a = 1'b1;
            tfc_pkg::wave_reserved: w.fixed_top = 16'hFFFF;
            tfc_pkg::wave_pfc_cap, tfc_pkg::wave_pc_cap: begin
                w.style = tfc_pkg::tfc_up_down;
                w.pwm = 1'b1;
                w.top_from_capture = 1'b1;
            end
            tfc_pkg::wave_pfc_a, tfc_pkg::wave_pc_a: begin
                w.style = tfc_pkg::tfc_up_down;
                w.pwm = 1'b1;
                w.top_from_a = 1'b1;
            end
            tfc_pkg::wave_fast_cap: begin
                w.style = tfc_pkg::tfc_up_fast;
                w.pwm = 1'b1;
                w.top_from_capture = 1'b1;
            end
            tfc_pkg::wave_fast_a: begin
                w.style = tfc_pkg::tfc_up_fast;
                w.pwm = 1'b1;
                w.top_from_a = 1'b1;
            end
            default: w.fixed_top = 16'hFFFF;
        endcase
        return w;
    endfunction : decode_wave

    // Output level after a match for a given output mode
    // Mode off keeps the level; only the enable drops
    function automatic logic next_level(input logic [1:0] mode, input logic cur);
        case (mode)
            tfc_pkg::com_toggle: next_level = ~cur;
            tfc_pkg::com_clear: next_level = 1'b0;
            tfc_pkg::com_set: next_level = 1'b1;
            default: next_level = cur;
        endcase
    endfunction : next_level

    // Software-visible registers and the shared high byte
    logic [7:0] control_a;
    logic [4:0] control_b;
    logic [15:0] counter_value;
    logic [7:0] temp_high;
    logic [15:0] compare_value [3];

    // Prescaler and external pin synchroniser
    logic [9:0] prescaler;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_prev;

    // Up-down direction and the one-tick match block
    logic counting_down;
    logic block_match;

    // APB decode; register index is byte address divided by four
    // Only aligned addresses in the low kilobyte are mapped
    wire logic [7:0] reg_index = paddr[9:2];
    wire logic in_range = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic rd = access && !pwrite;

    // One-hot register hits
    wire logic hit_ctla = in_range && reg_index == tfc_pkg::idx_control_a;
    wire logic hit_ctlb = in_range && reg_index == tfc_pkg::idx_control_b;
    wire logic hit_force = in_range && reg_index == tfc_pkg::idx_force_compare_control;
    wire logic hit_cnt_lo = in_range && reg_index == tfc_pkg::idx_counter_low_byte;
    wire logic hit_cnt_hi = in_range && reg_index == tfc_pkg::idx_counter_high_byte;
    wire logic hit_cap_lo = in_range && reg_index == tfc_pkg::idx_capture_low;
    wire logic hit_cap_hi = in_range && reg_index == tfc_pkg::idx_capture_high;

    // Compare bank: low and high bytes of channels A to C
    wire logic hit_cmp_lo = in_range && reg_index[7:3] == 5'h11 && reg_index[0] == 1'b0
        && reg_index[2:1] != 2'b11;
    wire logic hit_cmp_hi = in_range && reg_index[7:3] == 5'h11 && reg_index[0] == 1'b1
        && reg_index[2:1] != 2'b11;
    wire logic [1:0] cmp_idx = (reg_index >= tfc_pkg::idx_compare_a_low) ?
        2'(reg_index[2:1] - 2'b00) : 2'b00;

    // An access that hits nothing is refused
    wire logic hit_any = hit_ctla || hit_ctlb || hit_force || hit_cnt_lo || hit_cnt_hi
        || hit_cap_lo || hit_cap_hi || hit_cmp_lo || hit_cmp_hi;

    // Mode decode
    // Upper wave bits and clock select share control register B
    wire logic [3:0] waveform_mode = {control_b[4:3], control_a[1:0]};
    wire logic [2:0] clock_select = control_b[2:0];
    wire tfc_pkg::tfc_wave_type wave = decode_wave(waveform_mode);

    // TOP from the capture input, compare A or the fixed width
    wire logic [15:0] top_value = wave.top_from_capture ? capture_value :
        wave.top_from_a ? compare_value[0] : wave.fixed_top;

    // Clock source selection from prescaler taps or synchronised pin edges
    // Pin modes count edges even while the pin is driven out
    wire logic pin_fall = pin_prev && !pin_sync2;
    wire logic pin_rise = !pin_prev && pin_sync2;

    // Free-running prescaler; a tap fires as its low bits roll to zero
    wire logic [9:0] next_prescaler = prescaler + 10'h001;
    logic timer_tick;
    always_comb begin
        case (clock_select)
            tfc_pkg::clk_stop: timer_tick = 1'b0;
            tfc_pkg::clk_div1: timer_tick = 1'b1;
            tfc_pkg::clk_div8: timer_tick = next_prescaler[tfc_pkg::tap_div8:0] == '0;
            tfc_pkg::clk_div64: timer_tick = next_prescaler[tfc_pkg::tap_div64:0] == '0;
            tfc_pkg::clk_div256: timer_tick = next_prescaler[tfc_pkg::tap_div256:0] == '0;
            tfc_pkg::clk_div1024: timer_tick = next_prescaler[tfc_pkg::tap_div1024:0] == '0;
            tfc_pkg::clk_ext_fall: timer_tick = pin_fall;
            tfc_pkg::clk_ext_rise: timer_tick = pin_rise;
            default: timer_tick = 1'b0;
        endcase
    end

    // Counter sequencing
    // Up-down styles turn at TOP and zero; the others restart at zero
    // A counter write wins over counting in the same cycle
    wire logic at_top = counter_value >= top_value;
    wire logic at_bottom = counter_value == 16'h0000;
    wire logic cnt_write = wr && hit_cnt_lo;
    logic [15:0] next_counter;
    logic next_down;
    always_comb begin
        next_counter = counter_value;
        next_down = counting_down;
        if (timer_tick) begin
            case (wave.style)
                tfc_pkg::tfc_up_down: begin
                    if (counting_down && !at_bottom) begin
                        next_counter = counter_value - 16'h0001;
                    end else if (counting_down) begin
                        next_down = 1'b0;
                        next_counter = 16'h0001;
                    end else if (at_top) begin
                        next_down = 1'b1;
                        next_counter = counter_value - 16'h0001;
                    end else begin
                        next_counter = counter_value + 16'h0001;
                    end
                end
                tfc_pkg::tfc_up_fast: next_counter = at_top ? 16'h0000 : counter_value + 16'h0001;
                tfc_pkg::tfc_up_wrap: begin
                    if (wave.top_from_a && at_top) begin
                        next_counter = 16'h0000;
                    end else begin
                        next_counter = counter_value + 16'h0001;
                    end
                end
                default: next_counter = counter_value + 16'h0001;
            endcase
        end
        if (cnt_write) begin
            next_counter = {temp_high, pwdata[7:0]};
        end
    end

    // Compare matches, suppressed on the tick after a counter write
    // Matches and force strobes act only outside PWM modes
    // A force strobe never touches the counter
    wire logic match_ok = timer_tick && !block_match && !wave.pwm;
    wire logic [2:0] force_hit = (wr && hit_force && !wave.pwm) ?
        {pwdata[tfc_pkg::force_c_bit], pwdata[tfc_pkg::force_b_bit], pwdata[tfc_pkg::force_a_bit]}
        : 3'b000;

    // Output mode of each channel, A in slot 0
    logic [1:0] com_mode [3];
    assign com_mode[0] = control_a[7:6];
    assign com_mode[1] = control_a[5:4];
    assign com_mode[2] = control_a[3:2];

    // Read data mux; force bits and reserved bits read zero
    // Counter and capture high bytes return the shared high byte
    logic [7:0] read_byte;
    always_comb begin
        read_byte = 8'h00;
        if (hit_ctla) read_byte = control_a;
        else if (hit_ctlb) read_byte = {3'b000, control_b};
        else if (hit_force) read_byte = 8'h00;
        else if (hit_cnt_lo) read_byte = counter_value[7:0];
        else if (hit_cnt_hi) read_byte = temp_high;
        else if (hit_cap_lo) read_byte = capture_value[7:0];
        else if (hit_cap_hi) read_byte = temp_high;
        else if (hit_cmp_lo) read_byte = compare_value[cmp_idx][7:0];
        else if (hit_cmp_hi) read_byte = compare_value[cmp_idx][15:8];
    end

    // Control and compare registers
    // Reset leaves the timer stopped in normal mode
    // A compare low-byte write commits the parked high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_a <= tfc_pkg::control_reset;
            control_b <= 5'h00;
            compare_value <= '{3{tfc_pkg::word_reset}};
        end else if (wr) begin
            if (hit_ctla) control_a <= pwdata[7:0];
            if (hit_ctlb) control_b <= pwdata[4:0];
            if (hit_cmp_lo) compare_value[cmp_idx] <= {temp_high, pwdata[7:0]};
        end
    end

    // Shared temporary high byte: loaded on counter and compare high writes and on counter and capture low reads
    // Software writes high before low and reads low before high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_high <= 8'h00;
        end else if (wr && (hit_cnt_hi || hit_cmp_hi)) begin
            temp_high <= pwdata[7:0];
        end else if (rd && hit_cnt_lo) begin
            temp_high <= counter_value[15:8];
        end else if (rd && hit_cap_lo) begin
            temp_high <= capture_value[15:8];
        end
    end

    // Counter, direction, prescaler and pin edge capture
    // Only the second synchroniser stage feeds the edge detector
    // Setting the match block wins over clearing it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= tfc_pkg::word_reset;
            counting_down <= 1'b0;
            prescaler <= 10'h000;
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            pin_prev <= 1'b0;
            block_match <= 1'b0;
        end else begin
            counter_value <= next_counter;
            counting_down <= next_down;
            prescaler <= next_prescaler;
            pin_sync1 <= ext_count_pin;
            pin_sync2 <= pin_sync1;
            pin_prev <= pin_sync2;
            if (cnt_write) block_match <= 1'b1;
            else if (timer_tick) block_match <= 1'b0;
        end
    end

    // Waveform outputs: compare match or forced strobe per channel
    // A forced strobe takes priority over a match in the same cycle
    // Enables follow the output mode one clock after a control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out <= 3'b000;
            wave_out_en <= 3'b000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                wave_out_en[i] <= com_mode[i] != tfc_pkg::com_off;
                if (force_hit[i]) begin
                    wave_out[i] <= next_level(com_mode[i], wave_out[i]);
                end else if (match_ok && counter_value == compare_value[i]) begin
                    wave_out[i] <= next_level(com_mode[i], wave_out[i]);
                end
            end
        end
    end

    // APB answer: zero wait states, error on unmapped address
    // Registered from the setup cycle, so it stands only in the access phase
    // Writes take effect at the access edge, when pready is sampled high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, read_byte} : 32'h0000_0000;
        end
    end

endmodule : tfc_timer

/* File: rtl/tfc_pkg.sv */
package tfc_pkg;

    // Register byte offsets; printed offsets are not all multiples of four,
    // so each is an index and the byte address is four times the index
    localparam logic [7:0] idx_control_a = 8'h80;
    localparam logic [7:0] idx_control_b = 8'h81;
    localparam logic [7:0] idx_force_compare_control = 8'h82;
    localparam logic [7:0] idx_counter_low_byte = 8'h84;
    localparam logic [7:0] idx_counter_high_byte = 8'h85;
    localparam logic [7:0] idx_capture_low = 8'h86;
    localparam logic [7:0] idx_capture_high = 8'h87;
    localparam logic [7:0] idx_compare_a_low = 8'h88;
    localparam logic [7:0] idx_compare_a_high = 8'h89;
    localparam logic [7:0] idx_compare_b_low = 8'h8A;
    localparam logic [7:0] idx_compare_b_high = 8'h8B;
    localparam logic [7:0] idx_compare_c_low = 8'h8C;
    localparam logic [7:0] idx_compare_c_high = 8'h8D;

    // Field positions
    localparam int ctla_mode_a_lsb = 6;
    localparam int ctla_mode_b_lsb = 4;
    localparam int ctla_mode_c_lsb = 2;
    localparam int ctlb_wave_upper_lsb = 3;
    localparam int force_a_bit = 7;
    localparam int force_b_bit = 6;
    localparam int force_c_bit = 5;

    // Reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [15:0] word_reset = 16'h0000;

    // Prescaler tap bit positions (divide by 8, 64, 256, 1024)
    localparam int tap_div8 = 2;
    localparam int tap_div64 = 5;
    localparam int tap_div256 = 7;
    localparam int tap_div1024 = 9;

    // Waveform codes
    localparam logic [3:0] wave_normal = 4'h0;
    localparam logic [3:0] wave_ctc_a = 4'h4;
    localparam logic [3:0] wave_pfc_cap = 4'h8;
    localparam logic [3:0] wave_pfc_a = 4'h9;
    localparam logic [3:0] wave_pc_cap = 4'hA;
    localparam logic [3:0] wave_pc_a = 4'hB;
    localparam logic [3:0] wave_ctc_a2 = 4'hC;
    localparam logic [3:0] wave_reserved = 4'hD;
    localparam logic [3:0] wave_fast_cap = 4'hE;
    localparam logic [3:0] wave_fast_a = 4'hF;

    // Clock select codes
    localparam logic [2:0] clk_stop = 3'h0;
    localparam logic [2:0] clk_div1 = 3'h1;
    localparam logic [2:0] clk_div8 = 3'h2;
    localparam logic [2:0] clk_div64 = 3'h3;
    localparam logic [2:0] clk_div256 = 3'h4;
    localparam logic [2:0] clk_div1024 = 3'h5;
    localparam logic [2:0] clk_ext_fall = 3'h6;
    localparam logic [2:0] clk_ext_rise = 3'h7;

    // Compare output modes
    localparam logic [1:0] com_off = 2'h0;
    localparam logic [1:0] com_toggle = 2'h1;
    localparam logic [1:0] com_clear = 2'h2;
    localparam logic [1:0] com_set = 2'h3;

    // Counting style
    typedef enum logic [1:0] {
        tfc_up_wrap,
        tfc_up_down,
        tfc_up_fast
    } tfc_count_type;

    // Decoded waveform mode
    typedef struct packed {
        tfc_count_type style;
        logic pwm;
        logic top_from_capture;
        logic top_from_a;
        logic [15:0] fixed_top;
    } tfc_wave_type;

endpackage : tfc_pkg

/* File: verification/tfc_timer_sva.sv */
`timescale 1ns/1ps
module tfc_timer_sva (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic ext_count_pin,
    input wire logic [15:0] capture_value,
    input wire logic [2:0] wave_out,
    input wire logic [2:0] wave_out_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Address decode of the mapped byte locations
    wire logic mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
        && (paddr[9:2] >= 8'h80) && (paddr[9:2] <= 8'h8D) && (paddr[9:2] != 8'h83);
    wire logic ctla_wr = psel && penable && pwrite && (paddr == 12'h200);
    property p_ready_in_access; psel && penable |-> pready; endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("no ready in access");
    property p_ready_only; pready |-> psel && penable; endproperty
    a_ready_only: assert property (p_ready_only) else $error("ready outside access");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_unmapped; pready && !mapped |-> pslverr; endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_ok_mapped; pready && mapped |-> !pslverr; endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
    property p_force_zero; pready && !pwrite && paddr == 12'h208 |-> prdata[7:0] == 8'h00;
    endproperty
    a_force_zero: assert property (p_force_zero) else $error("force bits read nonzero");
    property p_en_mode;
        ctla_wr |-> ##2 wave_out_en == {|$past(pwdata[3:2], 2), |$past(pwdata[5:4], 2),
            |$past(pwdata[7:6], 2)};
    endproperty
    a_en_mode: assert property (p_en_mode) else $error("enable not from output mode");
    property p_en_hold; !ctla_wr && !$past(ctla_wr) |=> $stable(wave_out_en); endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved without write");
    property p_reset_quiet; $rose(presetn) |-> wave_out == 3'h0 && wave_out_en == 3'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not zero after reset");
    // Main scenarios
    c_refused: cover property (pready && pslverr);
    c_force: cover property (psel && penable && pwrite && paddr == 12'h208);
    c_en_write: cover property (ctla_wr);
endmodule : tfc_timer_sva
bind tfc_timer tfc_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
    .capture_value(capture_value), .wave_out(wave_out), .wave_out_en(wave_out_en));

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin = 1'b0;
    logic [15:0] cap = 16'h1234;
    logic [2:0] wave_out;
    logic [2:0] wave_out_en;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    tfc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(pin), .capture_value(cap), .wave_out(wave_out),
        .wave_out_en(wave_out_en));
    // Clock and hang guard
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction : ad
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask : check
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad(i);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Counter word: high byte first on write, low byte first on read
    task automatic cnt_wr(input logic [15:0] v);
        apb(1'b1, tfc_pkg::idx_counter_high_byte, {24'h0, v[15:8]});
        apb(1'b1, tfc_pkg::idx_counter_low_byte, {24'h0, v[7:0]});
    endtask : cnt_wr
    task automatic cnt_chk(input logic [15:0] x);
        apb(1'b0, tfc_pkg::idx_counter_low_byte, 32'h0);
        check("cnt_lo", {24'h0, rd[7:0]}, {24'h0, x[7:0]});
        apb(1'b0, tfc_pkg::idx_counter_high_byte, 32'h0);
        check("cnt_hi", {24'h0, rd[7:0]}, {24'h0, x[15:8]});
    endtask : cnt_chk
    task automatic t_reset_and_map();
        apb(1'b0, tfc_pkg::idx_force_compare_control, 32'h0);
        check("force_rst", rd, 32'h0);
        apb(1'b0, tfc_pkg::idx_control_b, 32'h0);
        check("ctlb_rst", {24'h0, rd[7:0]}, 32'h0);
        cnt_chk(16'h0000);
        apb(1'b0, tfc_pkg::idx_capture_low, 32'h0);
        check("cap_lo", rd, {24'h0, cap[7:0]});
        apb(1'b0, tfc_pkg::idx_capture_high, 32'h0);
        check("cap_hi", rd, {24'h0, cap[15:8]});
        apb(1'b1, 8'h83, 32'h000000FF);
        check("unmapped", {31'h0, er}, 32'h1);
    endtask : t_reset_and_map
    task automatic t_word_and_clock();
        cnt_wr(16'hA55A);
        repeat (20) @(posedge pclk);
        cnt_chk(16'hA55A);
        cnt_wr(16'h0000);
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_div1});
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_stop});
        apb(1'b0, tfc_pkg::idx_counter_low_byte, 32'h0);
        check("div1_count", {24'h0, rd[7:0]}, 32'h3);
    endtask : t_word_and_clock
    // Three pin edges of the selected polarity, pin held slow for the synchroniser
    task automatic t_ext(input logic [2:0] cs);
        cnt_wr(16'h0000);
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, cs});
        repeat (3) begin
            pin <= 1'b1;
            repeat (5) @(posedge pclk);
            pin <= 1'b0;
            repeat (5) @(posedge pclk);
        end
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_stop});
        cnt_chk(16'h0003);
    endtask : t_ext
    // Force strobes on all channels through the toggle, set and clear output modes
    task automatic t_force();
        logic [1:0] seq [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
        logic e;
        e = 1'b0;
        foreach (seq[k]) begin
            apb(1'b1, tfc_pkg::idx_control_a, {24'h0, seq[k], seq[k], seq[k], 2'h0});
            apb(1'b1, tfc_pkg::idx_force_compare_control, 32'h000000E0);
            e = (seq[k] == tfc_pkg::com_toggle) ? ~e : (seq[k] == tfc_pkg::com_set);
            @(posedge pclk);
            check("wave", {29'h0, wave_out}, {29'h0, {3{e}}});
            check("wave_en", {29'h0, wave_out_en}, 32'h7);
        end
        apb(1'b0, tfc_pkg::idx_force_compare_control, 32'h0);
        check("force_read", rd, 32'h0);
        apb(1'b1, tfc_pkg::idx_control_a, 32'h00000055);
        apb(1'b1, tfc_pkg::idx_force_compare_control, 32'h000000E0);
        @(posedge pclk);
        check("pwm_force", {29'h0, wave_out}, {29'h0, {3{e}}});
        apb(1'b1, tfc_pkg::idx_control_a, 32'h00000040);
        apb(1'b1, tfc_pkg::idx_control_b, 32'h00000008);
        cnt_wr(16'h0005);
        apb(1'b1, tfc_pkg::idx_force_compare_control, 32'h00000080);
        @(posedge pclk);
        check("ctc_wave", {31'h0, wave_out[0]}, {31'h0, ~e});
        cnt_chk(16'h0005);
    endtask : t_force
    // A counter write hides only the match on the next timer tick
    task automatic t_block();
        logic w;
        w = wave_out[0];
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_stop});
        apb(1'b1, tfc_pkg::idx_compare_a_high, 32'h0);
        apb(1'b1, tfc_pkg::idx_compare_a_low, 32'h00000003);
        cnt_wr(16'h0003);
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_div1});
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_stop});
        @(posedge pclk);
        check("match_blocked", {31'h0, wave_out[0]}, {31'h0, w});
        cnt_wr(16'h0002);
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_div1});
        apb(1'b1, tfc_pkg::idx_control_b, {29'h0, tfc_pkg::clk_stop});
        @(posedge pclk);
        check("match_after", {31'h0, wave_out[0]}, {31'h0, ~w});
    endtask : t_block
    // Three ticks from just below TOP show where the count turns or wraps
    task automatic t_turn(input logic [7:0] b, input logic [15:0] v, input logic [15:0] x);
        apb(1'b1, tfc_pkg::idx_control_a, 32'h00000002);
        apb(1'b1, tfc_pkg::idx_control_b, {24'h0, b});
        cnt_wr(v);
        apb(1'b1, tfc_pkg::idx_control_b, {24'h0, b[7:3], tfc_pkg::clk_div1});
        apb(1'b1, tfc_pkg::idx_control_b, {24'h0, b});
        cnt_chk(x);
    endtask : t_turn
    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_map();
        t_word_and_clock();
        t_ext(tfc_pkg::clk_ext_rise);
        t_ext(tfc_pkg::clk_ext_fall);
        t_force();
        t_block();
        t_turn(8'h00, 16'h01FE, 16'h01FD);
        t_turn(8'h18, 16'h1232, 16'h0000);
        print_verdict();
    end
endmodule : tb_top
